// ---- include/cpu_core_pkg.sv ----
`default_nettype none
package cpu_core_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int SP_W = 6;
	localparam int FLAGS_W = 5;
	localparam int NUM_SRC = 5;
	localparam int REG_ADDR_W = 3;
	localparam logic [6:0] STACK_PAGE = 7'h03;
	localparam logic [5:0] SP_RESET = 6'h3F;
	localparam logic [12:0] VEC_RESET = 13'h1FFE;
	localparam logic [12:0] VEC_SOFT = 13'h1FFC;
	localparam logic [12:0] VEC_EXT = 13'h1FFA;
	localparam logic [12:0] VEC_TIMER16 = 13'h1FF8;
	localparam logic [12:0] VEC_SERIAL = 13'h1FF6;
	localparam logic [12:0] VEC_CORE_TIMER = 13'h1FF4;
	localparam int FLAG_H = 4;
	localparam int FLAG_I = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;
	localparam logic [4:0] FLAGS_RESET = 5'h08;
	localparam logic [4:0] ENABLE_RESET = 5'h00;
	localparam logic [2:0] PUSH_LAST_CALL = 3'h1;
	localparam logic [2:0] PUSH_LAST_TRAP = 3'h4;
	localparam logic [2:0] PULL_LAST = 3'h4;
	localparam int SRC_EXT = 0;
	localparam int SRC_COMPARATOR_THREE_OUTPUT = 1;
	localparam int SRC_TIMER16 = 2;
	localparam int SRC_SERIAL = 3;
	localparam int SRC_CORE_TIMER = 4;
	localparam int IRQ_LATENCY_CYCLES = 10;
	localparam logic [2:0] REG_FLAGS = 3'h0;
	localparam logic [2:0] REG_STACK = 3'h1;
	localparam logic [2:0] REG_FP_LOW = 3'h2;
	localparam logic [2:0] REG_FP_HIGH = 3'h3;
	localparam logic [2:0] REG_ACC = 3'h4;
	localparam logic [2:0] REG_INDEX = 3'h5;
	localparam logic [2:0] REG_ENABLE = 3'h6;
	localparam logic [2:0] REG_PENDING = 3'h7;
	typedef enum logic [2:0] {
		ALU_ADD   = 3'h0,
		ALU_ADC   = 3'h1,
		ALU_SUB   = 3'h2,
		ALU_SBC   = 3'h3,
		ALU_LOGIC = 3'h4,
		ALU_SHL   = 3'h5,
		ALU_SHR   = 3'h6,
		ALU_BTST  = 3'h7
	} alu_op_type;
endpackage
`default_nettype wire

// ---- include/core_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface core_link_if;
	cpu_core_pkg::alu_op_type alu_op;
	logic [7:0]               alu_a;
	logic [7:0]               alu_b;
	logic                     alu_cin;
	logic [3:0]               flag_new;
	logic [3:0]               flag_upd;
	logic [4:0]               pend;
	logic                     sel_valid;
	logic [12:0]              sel_vector;
	logic [4:0]               sel_source;
	modport core (output alu_op, alu_a, alu_b, alu_cin, pend, input flag_new, flag_upd, sel_valid, sel_vector, sel_source);
	modport alu (input alu_op, alu_a, alu_b, alu_cin, output flag_new, flag_upd);
	modport sel (input pend, output sel_valid, sel_vector, sel_source);
endinterface
`default_nettype wire

// ---- design/flag_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
// Flag order on flag_new and flag_upd is half-carry, negative, zero, carry.
module flag_unit (
	core_link_if.alu lnk
);
	logic [8:0] wide;
	logic [4:0] nib;
	logic [7:0] res;
	logic       cin;

	always_comb begin
		cin = (lnk.alu_op == cpu_core_pkg::ALU_ADC || lnk.alu_op == cpu_core_pkg::ALU_SBC) ? lnk.alu_cin : 1'b0;
		wide = 9'h000;
		nib = 5'h00;
		res = lnk.alu_b;
		lnk.flag_upd = 4'h6;
		lnk.flag_new = 4'h0;
		unique case (lnk.alu_op)
			cpu_core_pkg::ALU_ADD, cpu_core_pkg::ALU_ADC: begin
				wide = {1'b0, lnk.alu_a} + {1'b0, lnk.alu_b} + {8'h00, cin};
				nib = {1'b0, lnk.alu_a[3:0]} + {1'b0, lnk.alu_b[3:0]} + {4'h0, cin};
				res = wide[7:0];
				lnk.flag_upd = 4'hF;
			end
			cpu_core_pkg::ALU_SUB, cpu_core_pkg::ALU_SBC: begin
				wide = {1'b0, lnk.alu_a} - {1'b0, lnk.alu_b} - {8'h00, cin};
				res = wide[7:0];
				lnk.flag_upd = 4'h7;
			end
			cpu_core_pkg::ALU_LOGIC: begin
				res = lnk.alu_b;
			end
			cpu_core_pkg::ALU_SHL: begin
				res = {lnk.alu_a[6:0], lnk.alu_cin};
				wide = {lnk.alu_a[7], 8'h00};
				lnk.flag_upd = 4'h7;
			end
			cpu_core_pkg::ALU_SHR: begin
				res = {lnk.alu_cin, lnk.alu_a[7:1]};
				wide = {lnk.alu_a[0], 8'h00};
				lnk.flag_upd = 4'h7;
			end
			cpu_core_pkg::ALU_BTST: begin
				// The tested bit of the operand, picked by alu_b, lands in carry for the branch.
				wide = {lnk.alu_a[lnk.alu_b[2:0]], 8'h00};
				lnk.flag_upd = 4'h1;
			end
		endcase
		lnk.flag_new = {nib[4], res[7], (res == 8'h00), wide[8]};
	end
endmodule
`default_nettype wire

// ---- design/irq_select.sv ----
`timescale 1ns/100ps
`default_nettype none
module irq_select (
	core_link_if.sel lnk
);
	always_comb begin
		lnk.sel_valid = |lnk.pend;
		lnk.sel_source = 5'h00;
		lnk.sel_vector = cpu_core_pkg::VEC_CORE_TIMER;
		// Highest vector address wins.
		if (lnk.pend[cpu_core_pkg::SRC_EXT]) begin
			lnk.sel_source[cpu_core_pkg::SRC_EXT] = 1'b1;
			lnk.sel_vector = cpu_core_pkg::VEC_EXT;
		end else if (lnk.pend[cpu_core_pkg::SRC_COMPARATOR_THREE_OUTPUT]) begin
			lnk.sel_source[cpu_core_pkg::SRC_COMPARATOR_THREE_OUTPUT] = 1'b1;
			lnk.sel_vector = cpu_core_pkg::VEC_EXT;
		end else if (lnk.pend[cpu_core_pkg::SRC_TIMER16]) begin
			lnk.sel_source[cpu_core_pkg::SRC_TIMER16] = 1'b1;
			lnk.sel_vector = cpu_core_pkg::VEC_TIMER16;
		end else if (lnk.pend[cpu_core_pkg::SRC_SERIAL]) begin
			lnk.sel_source[cpu_core_pkg::SRC_SERIAL] = 1'b1;
			lnk.sel_vector = cpu_core_pkg::VEC_SERIAL;
		end else if (lnk.pend[cpu_core_pkg::SRC_CORE_TIMER]) begin
			lnk.sel_source[cpu_core_pkg::SRC_CORE_TIMER] = 1'b1;
			lnk.sel_vector = cpu_core_pkg::VEC_CORE_TIMER;
		end
	end
endmodule
`default_nettype wire

// ---- design/cpu_interrupt_and_stack_core.sv ----
// Overview of operation
// - five-bit flags register, each bit testable
// - half-carry set on carry from bit three
// - masked pin edge stays latched until serviced; other requests are input levels
// - negative flag follows sign of result
// - zero flag follows zero result
// - carry from arithmetic, bit test, shift, rotate
// - reset or reinit instruction loads stack to FF
// - decrement after push, increment before pull
// - stack address is fixed page plus counter
// - six-bit stack counter wraps silently
// - call pushes two bytes, interrupt five
// - return low byte first, high byte next
// - thirteen-bit fetch pointer
// - interrupts wait for instruction completion
// - interrupt needs mask clear and source enabled
// - stack, set mask, then select pending source
// - highest vector address serviced first
// - soft trap taken regardless of mask
// - fetch two-byte vector from table
// - fixed vector address per source
// - entry latency at most ten extra cycles
// - trap return restores all stacked registers
// - reset sets mask and loads reset vector
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_and_stack_core (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_arst_n,
	input  wire logic [2:0]                 i_reg_addr,
	input  wire logic [7:0]                 i_reg_wdata,
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	output var  logic [7:0]                 o_reg_rdata,
	input  wire logic                       i_instr_done,
	input  wire logic [12:0]                i_next_fetch,
	input  wire logic                       i_soft_trap,
	input  wire logic                       i_trap_return,
	input  wire logic                       i_stack_reinit,
	input  wire logic                       i_call,
	input  wire logic [12:0]                i_call_target,
	input  wire logic                       i_alu_valid,
	input  wire cpu_core_pkg::alu_op_type   i_alu_op,
	input  wire logic [7:0]                 i_alu_a,
	input  wire logic [7:0]                 i_alu_b,
	input  wire logic                       i_ext_irq_n,
	input  wire logic                       i_comparator_three_output_req,
	input  wire logic                       i_timer16_req,
	input  wire logic                       i_serial_req,
	input  wire logic                       i_core_timer_req,
	output var  logic [12:0]                o_mem_addr,
	output var  logic [7:0]                 o_mem_wdata,
	output var  logic                       o_mem_wr,
	output var  logic                       o_mem_rd,
	input  wire logic [7:0]                 i_mem_rdata,
	output var  logic [12:0]                o_fetch_pointer,
	output var  logic [4:0]                 o_flags,
	output var  logic [5:0]                 o_stack_pointer,
	output var  logic                       o_busy
);
	localparam int LAT_MAX = cpu_core_pkg::IRQ_LATENCY_CYCLES;

	typedef enum logic [6:0] {
		st_run      = 7'h01,
		st_push     = 7'h02,
		st_pull     = 7'h04,
		st_pull_end = 7'h08,
		st_vec_hi   = 7'h10,
		st_vec_lo   = 7'h20,
		st_vec_end  = 7'h40
	} state_type;

	state_type   state;
	state_type   next_state;
	logic [2:0]  cnt;
	logic [2:0]  next_cnt;
	logic [2:0]  push_last;
	logic [2:0]  next_push_last;
	logic        is_call;
	logic        next_is_call;
	logic        is_hw;
	logic        next_is_hw;
	logic [5:0]  sp;
	logic [5:0]  next_sp;
	logic [4:0]  flags;
	logic [4:0]  next_flags;
	logic [12:0] fp;
	logic [12:0] next_fp;
	logic [12:0] ret_addr;
	logic [12:0] next_ret_addr;
	logic [12:0] vec;
	logic [12:0] next_vec;
	logic [7:0]  acc;
	logic [7:0]  next_acc;
	logic [7:0]  index;
	logic [7:0]  next_index;
	logic [4:0]  enable;
	logic [4:0]  next_enable;
	logic        ext_pend;
	logic        next_ext_pend;
	logic        ext_clear;
	logic [7:0]  next_rdata;
	logic        ext_meta;
	logic        ext_sync;
	logic        ext_prev;
	logic        ext_fall;
	logic [4:0]  pend_raw;
	logic        hw_take;
	logic [2:0]  pull_idx;

	core_link_if link ();

	flag_unit u_flag (
		.lnk (link)
	);

	irq_select u_select (
		.lnk (link)
	);

	function automatic logic [12:0] stack_addr(input logic [5:0] ptr);
		stack_addr = {cpu_core_pkg::STACK_PAGE, ptr};
	endfunction

	assign ext_fall = ext_prev & ~ext_sync;
	assign pend_raw = {i_core_timer_req, i_serial_req, i_timer16_req, i_comparator_three_output_req, ext_pend};
	assign link.pend = pend_raw & enable;
	assign link.alu_op = i_alu_op;
	assign link.alu_a = i_alu_a;
	assign link.alu_b = i_alu_b;
	assign link.alu_cin = flags[cpu_core_pkg::FLAG_C];
	assign hw_take = ~flags[cpu_core_pkg::FLAG_I] & (|link.pend);
	assign pull_idx = cnt - 3'h1;
	assign o_fetch_pointer = fp;
	assign o_flags = flags;
	assign o_stack_pointer = sp;
	assign o_busy = (state != st_run);

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ext_meta <= 1'b1;
			ext_sync <= 1'b1;
			ext_prev <= 1'b1;
		end else begin
			ext_meta <= i_ext_irq_n;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_push_last = push_last;
		next_is_call = is_call;
		next_is_hw = is_hw;
		next_sp = sp;
		next_flags = flags;
		next_fp = fp;
		next_ret_addr = ret_addr;
		next_vec = vec;
		next_acc = acc;
		next_index = index;
		next_enable = enable;
		next_rdata = 8'h00;
		ext_clear = 1'b0;
		o_mem_addr = 13'h0000;
		o_mem_wdata = 8'h00;
		o_mem_wr = 1'b0;
		o_mem_rd = 1'b0;
		if (i_reg_rd) begin
			case (i_reg_addr)
				cpu_core_pkg::REG_FLAGS:   next_rdata = {3'h0, flags};
				cpu_core_pkg::REG_STACK:   next_rdata = {2'h3, sp};
				cpu_core_pkg::REG_FP_LOW:  next_rdata = fp[7:0];
				cpu_core_pkg::REG_FP_HIGH: next_rdata = {3'h0, fp[12:8]};
				cpu_core_pkg::REG_ACC:     next_rdata = acc;
				cpu_core_pkg::REG_INDEX:   next_rdata = index;
				cpu_core_pkg::REG_ENABLE:  next_rdata = {3'h0, enable};
				cpu_core_pkg::REG_PENDING: next_rdata = {3'h0, pend_raw};
				default:                   next_rdata = 8'h00;
			endcase
		end
		if (i_reg_wr) begin
			case (i_reg_addr)
				cpu_core_pkg::REG_FLAGS:   next_flags = i_reg_wdata[4:0];
				cpu_core_pkg::REG_FP_LOW:  next_fp[7:0] = i_reg_wdata;
				cpu_core_pkg::REG_FP_HIGH: next_fp[12:8] = i_reg_wdata[4:0];
				cpu_core_pkg::REG_ACC:     next_acc = i_reg_wdata;
				cpu_core_pkg::REG_INDEX:   next_index = i_reg_wdata;
				cpu_core_pkg::REG_ENABLE:  next_enable = i_reg_wdata[4:0];
				default:                   next_enable = enable;
			endcase
		end
		unique case (state)
			st_run: begin
				if (i_alu_valid) begin
					if (link.flag_upd[3]) next_flags[cpu_core_pkg::FLAG_H] = link.flag_new[3];
					if (link.flag_upd[2]) next_flags[cpu_core_pkg::FLAG_N] = link.flag_new[2];
					if (link.flag_upd[1]) next_flags[cpu_core_pkg::FLAG_Z] = link.flag_new[1];
					if (link.flag_upd[0]) next_flags[cpu_core_pkg::FLAG_C] = link.flag_new[0];
				end
				// Requests are only looked at on the completion pulse of an instruction.
				if (i_instr_done) begin
					next_fp = i_next_fetch;
					next_ret_addr = i_next_fetch;
					next_cnt = 3'h0;
					if (i_stack_reinit) next_sp = cpu_core_pkg::SP_RESET;
					if (i_soft_trap) begin
						next_state = st_push;
						next_push_last = cpu_core_pkg::PUSH_LAST_TRAP;
						next_is_call = 1'b0;
						next_is_hw = 1'b0;
						next_vec = cpu_core_pkg::VEC_SOFT;
					end else if (i_trap_return) begin
						next_state = st_pull;
					end else if (i_call) begin
						next_state = st_push;
						next_fp = i_call_target;
						next_push_last = cpu_core_pkg::PUSH_LAST_CALL;
						next_is_call = 1'b1;
						next_is_hw = 1'b0;
					end else if (hw_take) begin
						next_state = st_push;
						next_push_last = cpu_core_pkg::PUSH_LAST_TRAP;
						next_is_call = 1'b0;
						next_is_hw = 1'b1;
					end
				end
			end
			st_push: begin
				o_mem_wr = 1'b1;
				o_mem_addr = stack_addr(sp);
				unique case (cnt)
					3'h0:    o_mem_wdata = ret_addr[7:0];
					3'h1:    o_mem_wdata = {3'h0, ret_addr[12:8]};
					3'h2:    o_mem_wdata = index;
					3'h3:    o_mem_wdata = acc;
					3'h4:    o_mem_wdata = {3'h7, flags};
					default: o_mem_wdata = 8'h00;
				endcase
				next_sp = sp - 6'h01;
				next_cnt = cnt + 3'h1;
				if (cnt == push_last) begin
					next_cnt = 3'h0;
					if (is_call) begin
						next_state = st_run;
					end else begin
						next_flags[cpu_core_pkg::FLAG_I] = 1'b1;
						next_state = st_vec_hi;
						// Selection happens only now, after the registers are on the stack.
						if (is_hw && link.sel_valid) begin
							next_vec = link.sel_vector;
							ext_clear = link.sel_source[cpu_core_pkg::SRC_EXT];
						end else if (is_hw) begin
							// The request went away during stacking, so unwind it.
							next_state = st_pull;
						end
					end
				end
			end
			st_pull: begin
				o_mem_rd = 1'b1;
				o_mem_addr = stack_addr(sp + 6'h01);
				next_sp = sp + 6'h01;
				next_cnt = cnt + 3'h1;
				if (cnt != 3'h0) begin
					unique case (pull_idx)
						3'h0:    next_flags = i_mem_rdata[4:0];
						3'h1:    next_acc = i_mem_rdata;
						3'h2:    next_index = i_mem_rdata;
						3'h3:    next_ret_addr[12:8] = i_mem_rdata[4:0];
						default: next_ret_addr = ret_addr;
					endcase
				end
				if (cnt == cpu_core_pkg::PULL_LAST) begin
					next_state = st_pull_end;
				end
			end
			st_pull_end: begin
				next_fp = {ret_addr[12:8], i_mem_rdata};
				next_cnt = 3'h0;
				next_state = st_run;
			end
			st_vec_hi: begin
				o_mem_rd = 1'b1;
				o_mem_addr = vec;
				next_state = st_vec_lo;
			end
			st_vec_lo: begin
				o_mem_rd = 1'b1;
				o_mem_addr = vec + 13'h0001;
				next_fp[12:8] = i_mem_rdata[4:0];
				next_state = st_vec_end;
			end
			st_vec_end: begin
				next_fp[7:0] = i_mem_rdata;
				next_state = st_run;
			end
		endcase
		// A new falling edge wins over the clear of the service.
		next_ext_pend = ext_fall | (ext_pend & ~ext_clear);
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= st_vec_hi;
			cnt <= 3'h0;
			push_last <= cpu_core_pkg::PUSH_LAST_TRAP;
			is_call <= 1'b0;
			is_hw <= 1'b0;
			sp <= cpu_core_pkg::SP_RESET;
			flags <= cpu_core_pkg::FLAGS_RESET;
			fp <= 13'h0000;
			ret_addr <= 13'h0000;
			vec <= cpu_core_pkg::VEC_RESET;
			acc <= 8'h00;
			index <= 8'h00;
			enable <= cpu_core_pkg::ENABLE_RESET;
			ext_pend <= 1'b0;
			o_reg_rdata <= 8'h00;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			push_last <= next_push_last;
			is_call <= next_is_call;
			is_hw <= next_is_hw;
			sp <= next_sp;
			flags <= next_flags;
			fp <= next_fp;
			ret_addr <= next_ret_addr;
			vec <= next_vec;
			acc <= next_acc;
			index <= next_index;
			enable <= next_enable;
			ext_pend <= next_ext_pend;
			o_reg_rdata <= next_rdata;
		end
	end

	logic accept_hw;
	logic accept_call;
	logic masked_idle;
	logic half_ref;
	assign accept_hw = (state == st_run) && i_instr_done && hw_take && !i_soft_trap && !i_trap_return && !i_call;
	assign accept_call = (state == st_run) && i_instr_done && i_call && !i_soft_trap && !i_trap_return;
	assign masked_idle = (state == st_run) && i_instr_done && flags[cpu_core_pkg::FLAG_I] && !i_soft_trap
		&& !i_trap_return && !i_call;
	assign half_ref = (5'({1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]}) >= 5'h10);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);

	sequence five_pushes;
		(state == st_push) [*5] ##1 (state != st_push);
	endsequence

	sequence two_pushes;
		(state == st_push) [*2] ##1 (state == st_run);
	endsequence

	stack_page_a: assert property ((o_mem_wr || (state == st_pull)) |-> o_mem_addr[12:6] == 7'h03)
		else $error("stack access outside fixed page");
	push_step_a: assert property ((state == st_push) |=> sp == 6'($past(sp) - 6'h01))
		else $error("stack pointer not decremented after push");
	trap_push_len_a: assert property (accept_hw |=> five_pushes)
		else $error("interrupt entry did not push five bytes");
	call_push_len_a: assert property (accept_call |=> two_pushes)
		else $error("call did not push two bytes");
	low_first_a: assert property (accept_hw |=> o_mem_wr && o_mem_wdata == $past(i_next_fetch[7:0]) ##1
		o_mem_wdata[4:0] == $past(i_next_fetch[12:8], 2))
		else $error("return address byte order wrong");
	mask_after_stack_a: assert property (accept_hw |=> !flags[cpu_core_pkg::FLAG_I] [*5] ##1
		flags[cpu_core_pkg::FLAG_I])
		else $error("mask bit not set at end of stacking");
	entry_latency_a: assert property (accept_hw |-> ##[1:LAT_MAX] (state == st_run))
		else $error("interrupt entry latency too long");
	masked_block_a: assert property (masked_idle |=> (state == st_run))
		else $error("masked interrupt was taken");
	soft_trap_a: assert property (((state == st_run) && i_instr_done && i_soft_trap) |=> (state == st_push)
		##5 (state == st_vec_hi) && o_mem_addr == 13'h1FFC)
		else $error("soft trap not taken through its vector");
	priority_a: assert property (((state == st_push) && cnt == 3'h4 && is_hw && link.pend[0]) |=>
		vec == 13'h1FFA)
		else $error("highest priority source not chosen");
	half_carry_a: assert property (((state == st_run) && i_alu_valid && i_alu_op == cpu_core_pkg::ALU_ADD) |=>
		flags[cpu_core_pkg::FLAG_H] == $past(half_ref))
		else $error("half carry flag wrong after add");
	reinit_a: assert property (((state == st_run) && i_instr_done && i_stack_reinit) |=> sp == 6'h3F)
		else $error("stack pointer not reinitialised");
endmodule
`default_nettype wire

// ---- verification/stack_memory_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// On-chip memory behind the core: stack page and vector table in one byte array.
module stack_memory_model (
	input  wire logic        i_ref_clk,
	input  wire logic [12:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output var  logic [7:0]  o_rdata
);
	logic [7:0] store [0:8191];
	initial begin
		for (int i = 0; i < 8192; i++) begin
			store[i] = i[7:0] ^ 8'hC3;
		end
		o_rdata = 8'h00;
	end
	// Read data stand only in the cycle after the strobe; otherwise the bus toggles so stale data never match.
	always @(posedge i_ref_clk) begin
		if (i_wr) begin
			store[i_addr] <= i_wdata;
		end
		if (i_rd) begin
			o_rdata <= store[i_addr];
		end else begin
			o_rdata <= ~o_rdata;
		end
	end
endmodule
`default_nettype wire

// ---- verification/cpu_interrupt_and_stack_core_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_and_stack_core_tb;
	logic                     clk, arst_n, reg_wr, reg_rd, done, strap, tret, reinit, call, alu_v, t16, ser;
	logic                     ext_n, comparator_three_output, ctim;
	logic [2:0]               reg_addr;
	logic [7:0]               reg_wdata, alu_a, alu_b, rd;
	logic [12:0]              nfetch, ctarget;
	cpu_core_pkg::alu_op_type alu_op;
	wire logic [12:0]         m_addr, fp;
	wire logic [7:0]          m_wdata, m_rdata, rdata;
	wire logic [4:0]          flags;
	wire logic [5:0]          sp;
	wire logic                m_wr, m_rd, busy;
	int                       failures, checks;

	cpu_interrupt_and_stack_core uut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_reg_addr(reg_addr),
		.i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata),
		.i_instr_done(done), .i_next_fetch(nfetch), .i_soft_trap(strap), .i_trap_return(tret),
		.i_stack_reinit(reinit), .i_call(call), .i_call_target(ctarget), .i_alu_valid(alu_v),
		.i_alu_op(alu_op), .i_alu_a(alu_a), .i_alu_b(alu_b), .i_ext_irq_n(ext_n), .i_comparator_three_output_req(comparator_three_output),
		.i_timer16_req(t16), .i_serial_req(ser), .i_core_timer_req(ctim), .o_mem_addr(m_addr),
		.o_mem_wdata(m_wdata), .o_mem_wr(m_wr), .o_mem_rd(m_rd), .i_mem_rdata(m_rdata),
		.o_fetch_pointer(fp), .o_flags(flags), .o_stack_pointer(sp), .o_busy(busy));
	stack_memory_model mem (.i_ref_clk(clk), .i_addr(m_addr), .i_wdata(m_wdata), .i_wr(m_wr), .i_rd(m_rd),
		.o_rdata(m_rdata));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic test_done;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 60; i++) begin
			@(negedge clk);
			if (busy === 1'b0) begin
				return;
			end
		end
		failures++;
		$display("wrong value busy expected 0 seen 1");
		test_done();
	endtask

	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	// Completes one instruction; the kind flags qualify the done pulse for one cycle only.
	task automatic finish(input logic [12:0] ret, input logic [3:0] kind, input logic [12:0] tgt);
		@(posedge clk);
		done    <= 1'b1;
		nfetch  <= ret;
		{strap, tret, reinit, call} <= kind;
		ctarget <= tgt;
		@(posedge clk);
		done    <= 1'b0;
		{strap, tret, reinit, call} <= 4'h0;
		wait_idle();
	endtask

	task automatic alu(input cpu_core_pkg::alu_op_type op, input logic [7:0] a, input logic [7:0] b,
		input logic [4:0] exp);
		@(posedge clk);
		alu_v  <= 1'b1;
		alu_op <= op;
		alu_a  <= a;
		alu_b  <= b;
		@(posedge clk);
		alu_v  <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("flags", {8'h00, exp}, {8'h00, flags});
	endtask

	task automatic test_reset;
		wait_idle();
		chk("fetch", 13'h0100, fp);
		chk("flags", 13'h0008, {8'h00, flags});
		chk("sp", 13'h003F, {7'h00, sp});
		reg_read(cpu_core_pkg::REG_STACK, rd);
		chk("stack reg", 13'h00FF, {5'h00, rd});
		$display("test reset done");
	endtask

	task automatic test_flags;
		alu(cpu_core_pkg::ALU_ADD, 8'h08, 8'h08, 5'b11000);
		alu(cpu_core_pkg::ALU_ADD, 8'h80, 8'h80, 5'b01011);
		alu(cpu_core_pkg::ALU_SUB, 8'h00, 8'h01, 5'b01101);
		alu(cpu_core_pkg::ALU_SHL, 8'h81, 8'h00, 5'b01001);
		alu(cpu_core_pkg::ALU_LOGIC, 8'h00, 8'h00, 5'b01011);
		alu(cpu_core_pkg::ALU_ADC, 8'h0F, 8'h00, 5'b11000);
		alu(cpu_core_pkg::ALU_BTST, 8'h04, 8'h02, 5'b11001);
		alu(cpu_core_pkg::ALU_SBC, 8'h05, 8'h04, 5'b11010);
		alu(cpu_core_pkg::ALU_SHR, 8'h01, 8'h00, 5'b11011);
		$display("test flags done");
	endtask

	task automatic test_irq;
		reg_write(cpu_core_pkg::REG_ACC, 8'h5A);
		reg_write(cpu_core_pkg::REG_INDEX, 8'hA5);
		reg_write(cpu_core_pkg::REG_ENABLE, 8'h0C);
		@(posedge clk);
		t16 <= 1'b1;
		ser <= 1'b1;
		finish(13'h1234, 4'h0, 13'h0000);
		chk("sp masked", 13'h003F, {7'h00, sp});
		reg_write(cpu_core_pkg::REG_FLAGS, 8'h00);
		finish(13'h1234, 4'h0, 13'h0000);
		chk("vector", 13'h0300, fp);
		chk("sp entry", 13'h003A, {7'h00, sp});
		chk("mask set", 13'h0001, {12'h000, flags[cpu_core_pkg::FLAG_I]});
		chk("push lo", 13'h0034, {5'h00, mem.store[13'h00FF]});
		chk("push hi", 13'h0012, {5'h00, mem.store[13'h00FE]});
		chk("push x", 13'h00A5, {5'h00, mem.store[13'h00FD]});
		chk("push a", 13'h005A, {5'h00, mem.store[13'h00FC]});
		chk("push flags", 13'h00E0, {5'h00, mem.store[13'h00FB]});
		@(posedge clk);
		t16 <= 1'b0;
		ser <= 1'b0;
		reg_write(cpu_core_pkg::REG_ACC, 8'h00);
		finish(13'h0301, 4'h4, 13'h0000);
		chk("return", 13'h1234, fp);
		chk("sp return", 13'h003F, {7'h00, sp});
		chk("flags return", 13'h0000, {8'h00, flags});
		reg_read(cpu_core_pkg::REG_ACC, rd);
		chk("acc return", 13'h005A, {5'h00, rd});
		$display("test irq done");
	endtask

	task automatic test_trap_call;
		reg_write(cpu_core_pkg::REG_FLAGS, 8'h08);
		finish(13'h0456, 4'h8, 13'h0000);
		chk("soft vector", 13'h0200, fp);
		chk("sp soft", 13'h003A, {7'h00, sp});
		finish(13'h0201, 4'h2, 13'h0000);
		chk("sp reinit", 13'h003F, {7'h00, sp});
		finish(13'h0777, 4'h1, 13'h0ABC);
		chk("call target", 13'h0ABC, fp);
		chk("sp call", 13'h003D, {7'h00, sp});
		chk("call lo", 13'h0077, {5'h00, mem.store[13'h00FF]});
		chk("call hi", 13'h0007, {5'h00, mem.store[13'h00FE]});
		for (int k = 1; k <= 32; k++) begin
			finish(k[12:0], 4'h1, 13'h0ABC);
		end
		chk("sp wrap", 13'h003D, {7'h00, sp});
		chk("wrap overwrite", 13'h0020, {5'h00, mem.store[13'h00FF]});
		$display("test trap and call done");
	endtask

	// Pin edge latched while masked; shared vector and core timer vector in priority order.
	task automatic test_ext;
		reg_write(cpu_core_pkg::REG_ENABLE, 8'h13);
		@(posedge clk);
		ext_n <= 1'b0;
		comparator_three_output  <= 1'b1;
		ctim  <= 1'b1;
		finish(13'h0123, 4'h0, 13'h0000);
		chk("sp held", 13'h003D, {7'h00, sp});
		reg_read(cpu_core_pkg::REG_PENDING, rd);
		chk("pending", 13'h0013, {5'h00, rd});
		reg_write(cpu_core_pkg::REG_FLAGS, 8'h00);
		finish(13'h0123, 4'h0, 13'h0000);
		chk("ext vector", 13'h0500, fp);
		reg_read(cpu_core_pkg::REG_PENDING, rd);
		chk("ext cleared", 13'h0012, {5'h00, rd});
		finish(13'h0501, 4'h4, 13'h0000);
		chk("ext return", 13'h0123, fp);
		finish(13'h0124, 4'h0, 13'h0000);
		chk("comparator_three_output vector", 13'h0500, fp);
		@(posedge clk);
		comparator_three_output  <= 1'b0;
		ext_n <= 1'b1;
		finish(13'h0501, 4'h4, 13'h0000);
		finish(13'h0125, 4'h0, 13'h0000);
		chk("core timer vector", 13'h0600, fp);
		@(posedge clk);
		ctim <= 1'b0;
		$display("test ext done");
	endtask

	initial begin
		failures = 0;
		checks   = 0;
		arst_n   = 1'b0;
		{reg_wr, reg_rd, done, strap, tret, reinit, call, alu_v, t16, ser} = 10'h000;
		{ext_n, comparator_three_output, ctim} = 3'h4;
		{reg_addr, reg_wdata, alu_a, alu_b} = 27'h0000000;
		{nfetch, ctarget} = 26'h0000000;
		alu_op = cpu_core_pkg::ALU_ADD;
		#1;
		{mem.store[13'h1FFE], mem.store[13'h1FFF]} = 16'h0100;
		{mem.store[13'h1FFC], mem.store[13'h1FFD]} = 16'h0200;
		{mem.store[13'h1FF8], mem.store[13'h1FF9]} = 16'h0300;
		{mem.store[13'h1FF6], mem.store[13'h1FF7]} = 16'h0400;
		{mem.store[13'h1FFA], mem.store[13'h1FFB]} = 16'h0500;
		{mem.store[13'h1FF4], mem.store[13'h1FF5]} = 16'h0600;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		test_reset();
		test_flags();
		test_irq();
		test_trap_call();
		test_ext();
		test_done();
	end
endmodule
`default_nettype wire
